/* File: dv/timer_match_dma_count_control_bench.sv */
// bench: match actions, dma requests and count control of the timer
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp); \
        end \
    end
module timer_match_dma_count_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [11:0] emc;
        logic [3:0] pins;
    } tmc_row_t;
    tmc_row_t rows [3] = '{'{12'hE40, 4'hC}, '{12'hE4F, 4'h5},
        '{12'h1B5, 4'h2}};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] cap = 4'h0;
    logic [3:0] pins;
    logic [1:0] dma_req;
    logic [1:0] dma_ack;
    logic irq;
    logic ack_en = 1'b1;
    logic [7:0] delay = 8'h00;
    logic [1:0] req_prev = 2'h0;
    logic [31:0] rdv;
    logic rde;
    int err_total = 0;
    int checked = 0;
    int req_rises = 0;
    int base;
    always #5 clk_sys = ~clk_sys;
    tmc_timer dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input(cap), .match_output_pin(pins), .dma_req(dma_req),
        .dma_ack(dma_ack), .irq(irq));
    tmc_dma_model dma_u (.clk_sys(clk_sys), .rst(rst), .ack_en(ack_en),
        .delay(delay), .dma_req(dma_req), .dma_ack(dma_ack));
    always @(posedge clk_sys)
    begin
        req_prev <= dma_req;
        if (dma_req[0] && !req_prev[0])
        begin
            req_rises++;
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        `CHK(n < 20, 1'b1)
        rdv = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic chk_rd(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        `CHK(rdv, exp)
    endtask
    task automatic start();
        wr(tmc_pkg::TIMER_COUNT_ADDR, 32'h0);
        wr(tmc_pkg::TIMER_ENABLE_ADDR, 32'h1);
    endtask
    task automatic stop();
        wr(tmc_pkg::TIMER_ENABLE_ADDR, 32'h0);
    endtask
    // selected input held two cycles a level, noise toggles every cycle
    task automatic drive_cap(input int idx, input int edges,
        input logic [3:0] noise);
        logic [3:0] sel;
        sel = 4'h1 << idx;
        for (int c = 0; c < 2 * edges; c++)
        begin
            cap <= cap ^ (noise & ~sel) ^ ((c % 2 == 0) ? sel : 4'h0);
            @(posedge clk_sys);
        end
    endtask
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int m = 0; m < 4; m++)
        begin
            wr(tmc_pkg::MATCH_VALUE_BASE_ADDR + 32'(4 * m), 32'h3);
        end
        foreach (rows[r])
        begin
            stop();
            wr(tmc_pkg::EXT_MATCH_CONTROL_ADDR, {20'h0, rows[r].emc});
            start();
            repeat (12) @(posedge clk_sys);
            stop();
            `CHK(pins, rows[r].pins)
            chk_rd(tmc_pkg::EXT_MATCH_CONTROL_ADDR,
                {20'h0, rows[r].emc[11:4], rows[r].pins});
        end
        $display("test match actions done");
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        `CHK({pins, dma_req, irq}, 7'h00)
        chk_rd(tmc_pkg::EXT_MATCH_CONTROL_ADDR, 32'h0);
        chk_rd(tmc_pkg::COUNT_CONTROL_ADDR, 32'h0);
        chk_rd(32'h40018000, 32'h0);
        `CHK(rde, 1'b1)
        $display("test reset done");
        delay <= 8'h10;
        wr(tmc_pkg::MATCH_VALUE_BASE_ADDR, 32'h0);
        wr(tmc_pkg::EXT_MATCH_CONTROL_ADDR, 32'h20);
        base = req_rises;
        start();
        repeat (4) @(posedge clk_sys);
        `CHK(dma_req[0], 1'b1)
        repeat (30) @(posedge clk_sys);
        `CHK(dma_req[0], 1'b0)
        stop();
        wr(tmc_pkg::EXT_MATCH_CONTROL_ADDR, 32'h0);
        start();
        repeat (10) @(posedge clk_sys);
        `CHK(req_rises - base, 1)
        stop();
        ack_en <= 1'b0;
        wr(tmc_pkg::EXT_MATCH_CONTROL_ADDR, 32'h30);
        wr(tmc_pkg::IRQ_MASK_ADDR, 32'h10);
        xfer(1'b0, tmc_pkg::IRQ_STATUS_ADDR, 32'h0);
        start();
        repeat (6) @(posedge clk_sys);
        `CHK({dma_req[0], irq}, 2'h3)
        wr(tmc_pkg::DMA_STATUS_ADDR, 32'h1);
        `CHK(dma_req[0], 1'b0)
        chk_rd(tmc_pkg::IRQ_STATUS_ADDR, 32'h1F);
        `CHK(irq, 1'b0)
        ack_en <= 1'b1;
        $display("test dma done");
        for (int md = 1; md < 4; md++)
        begin
            for (int s = 0; s < 4; s++)
            begin
                stop();
                wr(tmc_pkg::COUNT_CONTROL_ADDR, 32'(md + 4 * s));
                start();
                drive_cap(s, 6, 4'hF);
                stop();
                chk_rd(tmc_pkg::TIMER_COUNT_ADDR,
                    (md == 3) ? 32'h6 : 32'h3);
            end
        end
        $display("test counter mode done");
        for (int code = 0; code < 9; code++)
        begin
            stop();
            cap <= {4{code[0]}};
            wr(tmc_pkg::COUNT_CONTROL_ADDR, 32'(1 + 4 * ((code % 8 / 2 + 1)
                % 4) + 16 * (code < 8) + 32 * (code % 8)));
            start();
            drive_cap((code % 8 / 2 + 1) % 4, 6, 4'h0);
            drive_cap(code % 8 / 2, 1, 4'h0);
            stop();
            chk_rd(tmc_pkg::TIMER_COUNT_ADDR,
                (code < 8) ? 32'h0 : 32'h3);
        end
        $display("test capture clear done");
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        report_and_stop();
    end
endmodule // timer_match_dma_count_control_bench

/* File: dv/tmc_assertions.sv */
// checker: bus handshake and dma request timing of the timer
module tmc_assertions #(
    parameter int NUM_CAP = 4,
    parameter int NUM_MATCH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_CAP-1:0] capture_input,
    input wire logic [NUM_MATCH-1:0] match_output_pin,
    input wire logic [1:0] dma_req,
    input wire logic [1:0] dma_ack,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pin_prev_reg;
    logic [1:0] pin_rise;
    always_ff @(posedge clk_sys)
    begin
        pin_prev_reg <= rst ? 2'h0 : match_output_pin[1:0];
    end
    assign pin_rise = match_output_pin[1:0] & ~pin_prev_reg;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    property p_ready_once;
        pready |=> !pready [*2];
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("pready not a lone pulse");
    property p_ready_cause;
        pready |-> $past(psel && penable);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("pready without access phase");
    property p_answer;
        psel && !penable |-> ##[1:3] pready;
    endproperty
    a_answer: assert property (p_answer)
        else $error("transfer not answered");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr outside pready");
    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("prdata not zero when idle");
    property p_dma_set;
        pin_rise != 2'h0 |=> (dma_req & $past(pin_rise)) == $past(pin_rise);
    endproperty
    a_dma_set: assert property (p_dma_set)
        else $error("dma request missing after match bit rise");
    property p_dma_cause;
        (dma_req & ~$past(dma_req)) != 2'h0
            |-> (dma_req & ~$past(dma_req) & ~pin_rise) == 2'h0;
    endproperty
    a_dma_cause: assert property (p_dma_cause)
        else $error("dma request without match bit rise");
    property p_dma_clr;
        (dma_ack & dma_req & ~pin_rise) != 2'h0
            |=> (dma_req & ~pin_rise & $past(dma_ack & dma_req)) == 2'h0;
    endproperty
    a_dma_clr: assert property (p_dma_clr)
        else $error("dma request not cleared by ack");
endmodule // tmc_assertions

bind tmc_timer tmc_assertions #(.NUM_CAP(NUM_CAP), .NUM_MATCH(NUM_MATCH))
    chk_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input(capture_input),
    .match_output_pin(match_output_pin), .dma_req(dma_req),
    .dma_ack(dma_ack), .irq(irq));

/* File: dv/tmc_dma_model.sv */
// dma controller model: acknowledges each request after a set delay
module tmc_dma_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ack_en,
    input wire logic [7:0] delay,
    input wire logic [1:0] dma_req,
    output logic [1:0] dma_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_reg [2];
    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < 2; i++)
        begin
            dma_ack[i] <= 1'b0;
            // no ack in the cycle after one: request still visible then
            if (rst || !dma_req[i] || dma_ack[i])
            begin
                wait_reg[i] <= 8'h00;
            end
            else if (wait_reg[i] < delay)
            begin
                wait_reg[i] <= wait_reg[i] + 8'h01;
            end
            else
            begin
                dma_ack[i] <= ack_en;
            end
        end
    end
endmodule // tmc_dma_model

/* File: hdl/tmc_match_regs.sv */
// small register memory holding the four match values
module tmc_match_regs #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data,
    output logic [DEPTH*WIDTH-1:0] all_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    initial
    begin
        if (DEPTH < 2 || WIDTH < 1)
        begin
            $error("tmc_match_regs: bad size");
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_reg[i] <= '0;
            end
        end
        else if (wr_en)
        begin
            mem_reg[wr_idx] <= wr_data;
        end
    end

    // read data registered
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= mem_reg[rd_idx];
        end
    end

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_flat
            assign all_data[g*WIDTH +: WIDTH] = mem_reg[g];
        end
    endgenerate
endmodule // tmc_match_regs

/* File: hdl/tmc_timer.sv */
// timer/counter core: match outputs, dma requests, count control, apb slave
//
// Our own choice: register access over APB.
module tmc_timer #(
    parameter int NUM_CAP = 4,
    parameter int NUM_MATCH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CAP-1:0] capture_input,
    output logic [NUM_MATCH-1:0] match_output_pin,
    output logic [1:0] dma_req,
    input wire logic [1:0] dma_ack,
    output logic irq
);
    initial
    begin
        if (NUM_CAP != 4 || NUM_MATCH != 4)
        begin
            $error("tmc_timer: four capture and match channels only");
        end
    end

    // edge-select decode used for counting; the clear event picks its edge with clrsel[0]
    function automatic logic edge_hit(input logic [1:0] mode,
                                      input logic rise, input logic fall);
        unique case (mode)
            tmc_pkg::TMC_MODE_RISE: edge_hit = rise;
            tmc_pkg::TMC_MODE_FALL: edge_hit = fall;
            tmc_pkg::TMC_MODE_BOTH: edge_hit = rise | fall;
            tmc_pkg::TMC_MODE_TIMER: edge_hit = 1'b0;
        endcase
    endfunction

    logic [11:0] emc_reg;
    logic [7:0] cc_reg;
    logic [31:0] tc_reg;
    logic [31:0] pc_reg;
    logic [31:0] pr_reg;
    logic en_reg;
    logic [tmc_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [tmc_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [NUM_CAP-1:0] cap_prev_reg;
    logic [1:0] dma_reg;
    logic [NUM_MATCH-1:0] mat_reg;
    tmc_pkg::tmc_bus_t bus_reg;

    // bus decode
    logic acc;
    logic wr;
    logic rd;
    logic sel_emc, sel_cc, sel_mv, sel_tc, sel_pc, sel_pr, sel_en;
    logic sel_ist, sel_imk, sel_dma;
    logic mapped;
    assign acc = psel && penable && (bus_reg == tmc_pkg::TMC_BUS_ACCESS);
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign sel_emc = paddr == tmc_pkg::EXT_MATCH_CONTROL_ADDR;
    assign sel_cc = paddr == tmc_pkg::COUNT_CONTROL_ADDR;
    assign sel_mv = paddr[31:4] == tmc_pkg::MATCH_VALUE_BASE_ADDR[31:4]
        && paddr[1:0] == 2'h0;
    assign sel_tc = paddr == tmc_pkg::TIMER_COUNT_ADDR;
    assign sel_pc = paddr == tmc_pkg::PRESCALE_COUNT_ADDR;
    assign sel_pr = paddr == tmc_pkg::PRESCALE_LIMIT_ADDR;
    assign sel_en = paddr == tmc_pkg::TIMER_ENABLE_ADDR;
    assign sel_ist = paddr == tmc_pkg::IRQ_STATUS_ADDR;
    assign sel_imk = paddr == tmc_pkg::IRQ_MASK_ADDR;
    assign sel_dma = paddr == tmc_pkg::DMA_STATUS_ADDR;
    assign mapped = sel_emc | sel_cc | sel_mv | sel_tc | sel_pc | sel_pr
        | sel_en | sel_ist | sel_imk | sel_dma;

    // match value store
    logic [31:0] mv_rd;
    logic [NUM_MATCH*32-1:0] mv_all;
    tmc_match_regs #(
        .WIDTH(32),
        .DEPTH(NUM_MATCH)
    ) u_match_regs (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(wr && sel_mv),
        .wr_idx(paddr[3:2]),
        .wr_data(pwdata),
        .rd_idx(paddr[3:2]),
        .rd_data(mv_rd),
        .all_data(mv_all)
    );

    // capture edge classification, inputs already synchronous
    logic [NUM_CAP-1:0] cap_rise;
    logic [NUM_CAP-1:0] cap_fall;
    assign cap_rise = capture_input & ~cap_prev_reg;
    assign cap_fall = ~capture_input & cap_prev_reg;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cap_prev_reg <= '0;
        end
        else
        begin
            cap_prev_reg <= capture_input;
        end
    end

    // count source and clear event
    logic [1:0] mode;
    logic [1:0] insel;
    logic [2:0] clrsel;
    logic cnt_evt;
    logic clr_evt;
    logic tick;
    assign mode = cc_reg[tmc_pkg::CC_MODE_POS +: 2];
    assign insel = cc_reg[tmc_pkg::CC_INSEL_POS +: 2];
    assign clrsel = cc_reg[tmc_pkg::CC_CLRSEL_POS +: 3];
    assign cnt_evt = (mode == tmc_pkg::TMC_MODE_TIMER) ? 1'b1
        : edge_hit(mode, cap_rise[insel], cap_fall[insel]);
    assign clr_evt = cc_reg[tmc_pkg::CC_CLREN_POS]
        && (clrsel[0] ? cap_fall[clrsel[2:1]]
                      : cap_rise[clrsel[2:1]]);
    assign tick = en_reg && cnt_evt && (pc_reg >= pr_reg);

    // matches flagged on the tick where the count equals the value;
    // a value of zero matches on the first tick while the count sits at zero
    logic [NUM_MATCH-1:0] match_hit;
    genvar g;
    generate
        for (g = 0; g < NUM_MATCH; g++)
        begin : g_match
            assign match_hit[g] = tick
                && (tc_reg == mv_all[g*32 +: 32]);
        end
    endgenerate

    // prescaler and timer count; clear wins over counting
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pc_reg <= '0;
        end
        else if (wr && sel_pc)
        begin
            pc_reg <= pwdata;
        end
        else if (clr_evt)
        begin
            pc_reg <= '0;
        end
        else if (en_reg && cnt_evt)
        begin
            pc_reg <= tick ? 32'h00000000 : pc_reg + 32'h00000001;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tc_reg <= '0;
        end
        else if (wr && sel_tc)
        begin
            tc_reg <= pwdata;
        end
        else if (clr_evt)
        begin
            tc_reg <= '0;
        end
        else if (tick)
        begin
            tc_reg <= tc_reg + 32'h00000001;
        end
    end

    // external match bits
    logic [NUM_MATCH-1:0] mat_next;
    // a bus write feeds the same path so pin, bit and dma edge agree
    always_comb
    begin
        mat_next = mat_reg;
        if (wr && sel_emc)
        begin
            mat_next = pwdata[tmc_pkg::EMC_BIT_POS +: NUM_MATCH];
        end
        for (int i = 0; i < NUM_MATCH; i++)
        begin
            if (match_hit[i])
            begin
                unique case (emc_reg[tmc_pkg::EMC_ACT_POS + 2*i +: 2])
                    tmc_pkg::TMC_ACT_NONE: mat_next[i] = mat_next[i];
                    tmc_pkg::TMC_ACT_LOW: mat_next[i] = 1'b0;
                    tmc_pkg::TMC_ACT_HIGH: mat_next[i] = 1'b1;
                    tmc_pkg::TMC_ACT_TOGGLE: mat_next[i] = ~mat_next[i];
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mat_reg <= '0;
        end
        else
        begin
            mat_reg <= mat_next;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            match_output_pin <= '0;
        end
        else
        begin
            match_output_pin <= mat_next;
        end
    end

    // dma request: rising match bit sets, ack or software write clears;
    // set wins so no edge is lost
    logic [1:0] dma_set;
    logic [1:0] dma_next;
    assign dma_set = mat_next[1:0] & ~mat_reg[1:0];
    always_comb
    begin
        dma_next = dma_reg;
        for (int i = 0; i < 2; i++)
        begin
            if (dma_set[i])
            begin
                dma_next[i] = 1'b1;
            end
            else if (dma_ack[i])
            begin
                dma_next[i] = 1'b0;
            end
            else if (wr && sel_dma && pwdata[i])
            begin
                dma_next[i] = 1'b0;
            end
        end
    end

    // request pin drops the edge after ack, so no second ack
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dma_reg <= '0;
            dma_req <= '0;
        end
        else
        begin
            dma_reg <= dma_next;
            dma_req <= dma_next;
        end
    end

    // configuration registers; reserved bits dropped
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            emc_reg <= tmc_pkg::EMC_RESET;
            cc_reg <= tmc_pkg::CC_RESET;
            pr_reg <= '0;
            en_reg <= 1'b0;
            irq_mask_reg <= '0;
        end
        else if (wr)
        begin
            if (sel_emc)
            begin
                emc_reg <= pwdata[tmc_pkg::EMC_USED_W-1:0];
            end
            if (sel_cc)
            begin
                cc_reg <= pwdata[tmc_pkg::CC_USED_W-1:0];
            end
            if (sel_pr)
            begin
                pr_reg <= pwdata;
            end
            if (sel_en)
            begin
                en_reg <= pwdata[0];
            end
            if (sel_imk)
            begin
                irq_mask_reg <= pwdata[tmc_pkg::IRQ_W-1:0];
            end
        end
    end

    // sticky status, cleared by reading; new events win
    logic [tmc_pkg::IRQ_W-1:0] irq_evt;
    assign irq_evt = {dma_set, match_hit};
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            irq_stat_reg <= '0;
        end
        else if (rd && sel_ist)
        begin
            irq_stat_reg <= irq_evt;
        end
        else
        begin
            irq_stat_reg <= irq_stat_reg | irq_evt;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // apb: one wait state so the match store read settles
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            bus_reg <= tmc_pkg::TMC_BUS_IDLE;
        end
        else
        begin
            unique case (bus_reg)
                tmc_pkg::TMC_BUS_IDLE:
                    if (psel && !penable)
                    begin
                        bus_reg <= tmc_pkg::TMC_BUS_ACCESS;
                    end
                tmc_pkg::TMC_BUS_ACCESS:
                    bus_reg <= tmc_pkg::TMC_BUS_DONE;
                tmc_pkg::TMC_BUS_DONE:
                    bus_reg <= tmc_pkg::TMC_BUS_IDLE;
                default:
                    bus_reg <= tmc_pkg::TMC_BUS_IDLE;
            endcase
        end
    end

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h00000000;
        if (sel_emc)
        begin
            rd_mux = {20'h00000, emc_reg[11:4], mat_reg};
        end
        else if (sel_cc)
        begin
            rd_mux = {24'h000000, cc_reg};
        end
        else if (sel_mv)
        begin
            rd_mux = mv_rd;
        end
        else if (sel_tc)
        begin
            rd_mux = tc_reg;
        end
        else if (sel_pc)
        begin
            rd_mux = pc_reg;
        end
        else if (sel_pr)
        begin
            rd_mux = pr_reg;
        end
        else if (sel_en)
        begin
            rd_mux = {31'h00000000, en_reg};
        end
        else if (sel_ist)
        begin
            rd_mux = {26'h0000000, irq_stat_reg};
        end
        else if (sel_imk)
        begin
            rd_mux = {26'h0000000, irq_mask_reg};
        end
        else if (sel_dma)
        begin
            rd_mux = {30'h00000000, dma_reg};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= acc;
            pslverr <= acc && !mapped;
            prdata <= (acc && !pwrite) ? rd_mux : 32'h00000000;
        end
    end
endmodule // tmc_timer

/* File: pkg/tmc_pkg.sv */
// package: register map, field layout and constants for the match/count block
package tmc_pkg;
    // byte addresses of the registers
    localparam logic [31:0] EXT_MATCH_CONTROL_ADDR = 32'h4001803C;
    localparam logic [31:0] COUNT_CONTROL_ADDR = 32'h40018070;
    localparam logic [31:0] MATCH_VALUE_BASE_ADDR = 32'h40018080;
    localparam logic [31:0] TIMER_COUNT_ADDR = 32'h40018090;
    localparam logic [31:0] PRESCALE_COUNT_ADDR = 32'h40018094;
    localparam logic [31:0] PRESCALE_LIMIT_ADDR = 32'h40018098;
    localparam logic [31:0] TIMER_ENABLE_ADDR = 32'h4001809C;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h400180A0;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h400180A4;
    localparam logic [31:0] DMA_STATUS_ADDR = 32'h400180A8;

    // ext_match_control layout
    localparam int EMC_BIT_POS = 0;
    localparam int EMC_ACT_POS = 4;
    localparam int EMC_ACT_W = 2;
    localparam int EMC_USED_W = 12;
    localparam logic [11:0] EMC_RESET = 12'h000;

    // count_control layout
    localparam int CC_MODE_POS = 0;
    localparam int CC_INSEL_POS = 2;
    localparam int CC_CLREN_POS = 4;
    localparam int CC_CLRSEL_POS = 5;
    localparam int CC_USED_W = 8;
    localparam logic [7:0] CC_RESET = 8'h00;

    // match actions
    typedef enum logic [1:0] {
        TMC_ACT_NONE = 2'h0,
        TMC_ACT_LOW = 2'h1,
        TMC_ACT_HIGH = 2'h2,
        TMC_ACT_TOGGLE = 2'h3
    } tmc_act_t;

    // count modes
    typedef enum logic [1:0] {
        TMC_MODE_TIMER = 2'h0,
        TMC_MODE_RISE = 2'h1,
        TMC_MODE_FALL = 2'h2,
        TMC_MODE_BOTH = 2'h3
    } tmc_mode_t;

    // apb slave states, gray along setup -> access
    typedef enum logic [1:0] {
        TMC_BUS_IDLE = 2'b00,
        TMC_BUS_ACCESS = 2'b01,
        TMC_BUS_DONE = 2'b11
    } tmc_bus_t;

    // irq status bits: match 0..3 flags, dma request 0..1
    localparam int IRQ_W = 6;
    localparam int IRQ_DMA_POS = 4;
endpackage
